// >>> logic/mds_pkg.sv
// Package: register map, field layout, reset values and timing constants of the drum sequencer
package mds_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam real BASE_TICK_S = 0.01;
    localparam int unsigned BASE_TICK_CYC = int'(BASE_TICK_S * CLK_HZ);
    localparam int unsigned NSTEP = 16;
    localparam int unsigned NOUT = 16;
    localparam logic [15:0] CPS_MAX = 16'h270F;
    localparam logic [15:0] TBASE_MAX = 16'h270F;
    localparam logic [4:0] PRESET_MIN = 5'h01;
    localparam logic [4:0] PRESET_MAX = 5'h10;
    localparam logic [4:0] PRESET_RST = 5'h01;
    localparam logic [15:0] TBASE_RST = 16'h000A;
    localparam logic [15:0] CPS_RST = 16'h0000;
    localparam logic [15:0] PAT_RST = 16'h0000;
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [4:0] EVSEL_BLANK = 5'h1F;
    localparam logic [11:0] ADDR_COUNT = 12'h000;
    localparam logic [11:0] ADDR_TIMER = 12'h004;
    localparam logic [11:0] ADDR_PRESET = 12'h008;
    localparam logic [11:0] ADDR_CURSTEP = 12'h00C;
    localparam logic [11:0] ADDR_CTRL = 12'h010;
    localparam logic [11:0] ADDR_TBASE = 12'h014;
    localparam logic [11:0] ADDR_MASK0 = 12'h100;
    localparam logic [11:0] ADDR_PAT0 = 12'h200;
    localparam logic [11:0] ADDR_CPS0 = 12'h300;
    localparam logic [11:0] ADDR_EVS0 = 12'h400;
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned CTRL_START_BIT = 1;
    localparam int unsigned CTRL_JOG_BIT = 2;
    localparam int unsigned CTRL_RST_BIT = 3;
    localparam int unsigned CTRL_WORD_BIT = 4;
    localparam int unsigned COUNT_DONE_BIT = 16;
    typedef enum logic [1:0] {
        MDS_IDLE = 2'b00,
        MDS_RUN = 2'b01,
        MDS_DONE = 2'b10
    } mds_state_t;
endpackage

// >>> logic/mds_tick.sv
// Base tick divider and timer-base scaler producing one pulse per timer count
`timescale 1ns/1ps
module mds_tick (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic enable,
    input wire logic [15:0] tbase,
    output logic count_tick,
    output logic [15:0] timer_value
);
    import mds_pkg::*;
    logic [17:0] base_cnt_r;
    logic base_tick;
    logic [15:0] tb_cnt_r;

    assign base_tick = enable && (base_cnt_r == 18'(BASE_TICK_CYC - 1));
    assign timer_value = tb_cnt_r;

    always_ff @(posedge ref_clk) begin
        if (srst || !enable) begin
            base_cnt_r <= '0;
        end else if (base_tick) begin
            base_cnt_r <= '0;
        end else begin
            base_cnt_r <= base_cnt_r + 18'h00001;
        end
    end

    // Count lasts tbase base ticks; tbase of zero counts every base tick
    always_ff @(posedge ref_clk) begin
        if (srst || !enable) begin
            tb_cnt_r <= '0;
            count_tick <= 1'b0;
        end else begin
            count_tick <= 1'b0;
            if (base_tick) begin
                if (tb_cnt_r + 16'h0001 >= tbase) begin // R10
                    tb_cnt_r <= '0;
                    count_tick <= 1'b1;
                end else begin
                    tb_cnt_r <= tb_cnt_r + 16'h0001;
                end
            end
        end
    end

    tick_period_a: assert property (@(posedge ref_clk) disable iff (srst) // R10
        count_tick |-> !$past(count_tick)) else $error("count tick repeated");
endmodule // mds_tick

// >>> logic/mds_seq.sv
// Masked event drum sequencer: sixteen steps, masks, status words and APB register file
//
// Contract
// R1 - Sixteen steps, each with its own sixteen-bit output pattern.
// R2 - Outputs are current pattern ANDed with that step's mask word.
// R3 - Each rising jog edge advances one step regardless of timer and event.
// R4 - Step timer runs only while start is asserted.
// R5 - Timer counts only while the step's event is true; blank event means timed.
// R6 - Step advances when count equals counts-per-step, range 0 to 9999.
// R7 - Sequencing halts after last step completes or on reset input.
// R8 - Program-to-run entry and reset input load the preset step.
// R9 - Preset limited to 1..16; program may write it any time.
// R10 - One timer count lasts timer base times 0.01 second.
// R11 - Four status words: count, timer, preset, current step; only preset writable.
// R12 - Completion flag set when last step finishes, cleared by reset.
// R13 - Mask updates accepted any time and applied to outputs.
// R14 - Word variant writes masked bits as one word to its destination.
// R15 - Unconfigured steps and events default blank.
// R16 - Program loads masks for used steps, zeros on first scan if needed.
// R17 - Jog edge in last step carries sequencer to completed state.
// R18 - Outputs active in run mode; after entry show preset step pattern.
// R19 - Every step change clears the count within the step.
`timescale 1ns/1ps
module mds_seq (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] event_in,
    output logic [15:0] masked_drum_discrete_out,
    output logic [15:0] masked_drum_word_out,
    output logic drum_completion_flag
);
    import mds_pkg::*;

    logic [15:0] mask_r [NSTEP];
    logic [15:0] pat_r [NSTEP];
    logic [15:0] cps_r [NSTEP];
    logic [4:0] evs_r [NSTEP];
    logic [4:0] preset_r;
    logic [15:0] tbase_r;
    logic run_r, start_r, jog_r, rst_in_r, word_mode_r;
    logic run_d_r, jog_d_r;
    logic [3:0] step_r;
    logic [15:0] count_r;
    mds_state_t state_r;
    logic count_tick;
    logic [15:0] timer_value;
    logic wr_en, rd_en, jog_edge, run_entry, load_preset, ev_ok, timer_en;
    logic at_limit, advance;
    logic [15:0] masked;
    logic [11:0] sub;
    logic [31:0] rd_nxt;
    logic err_nxt;
    logic [4:0] wr_preset;

    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && !penable;
    assign sub = paddr & 12'h0FC;
    assign jog_edge = jog_r && !jog_d_r; // R3
    assign run_entry = run_r && !run_d_r;
    assign load_preset = run_entry || rst_in_r; // R8
    // Selectors above 15, the blank code among them, make the step purely time based
    assign ev_ok = evs_r[step_r][4] || event_in[evs_r[step_r][3:0]]; // R5 R15
    assign timer_en = run_r && start_r && (state_r == MDS_RUN) && ev_ok && !rst_in_r; // R4 R5
    // Advance on the tick that brings the count up to counts-per-step
    assign at_limit = (count_r + 16'h0001 >= cps_r[step_r]); // R6
    assign advance = run_r && (state_r == MDS_RUN) && !load_preset
        && (jog_edge || (timer_en && count_tick && at_limit)); // R3 R6
    assign masked = pat_r[step_r] & mask_r[step_r]; // R2
    // Upper clamp first, so a large value cannot alias to a low step
    assign wr_preset = (pwdata[15:0] > 16'(PRESET_MAX)) ? PRESET_MAX :
        (pwdata[4:0] < PRESET_MIN) ? PRESET_MIN : pwdata[4:0];

    // Timer scaler is held clear whenever the step timer is gated off
    mds_tick u_tick (
        .ref_clk(ref_clk),
        .srst(srst),
        .enable(timer_en),
        .tbase(tbase_r),
        .count_tick(count_tick),
        .timer_value(timer_value)
    );

    // Per-step configuration words, all blank after reset
    genvar gi;
    generate
        for (gi = 0; gi < NSTEP; gi++) begin : g_step // R1
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    mask_r[gi] <= MASK_RST;
                    pat_r[gi] <= PAT_RST;
                    cps_r[gi] <= CPS_RST; // R15
                    evs_r[gi] <= EVSEL_BLANK; // R15
                end else if (wr_en) begin
                    if (paddr == ADDR_MASK0 + 12'(gi * 4))
                        mask_r[gi] <= pwdata[15:0]; // R13
                    if (paddr == ADDR_PAT0 + 12'(gi * 4))
                        pat_r[gi] <= pwdata[15:0];
                    if (paddr == ADDR_CPS0 + 12'(gi * 4))
                        cps_r[gi] <= (pwdata[15:0] > CPS_MAX) ? CPS_MAX : pwdata[15:0]; // R6
                    if (paddr == ADDR_EVS0 + 12'(gi * 4))
                        evs_r[gi] <= pwdata[4:0];
                end
            end
        end
    endgenerate

    // Global control and preset registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            preset_r <= PRESET_RST;
            tbase_r <= TBASE_RST;
            run_r <= 1'b0;
            start_r <= 1'b0;
            jog_r <= 1'b0;
            rst_in_r <= 1'b0;
            word_mode_r <= 1'b0;
        end else if (wr_en) begin
            if (paddr == ADDR_PRESET)
                preset_r <= wr_preset; // R9 R11
            if (paddr == ADDR_TBASE)
                tbase_r <= (pwdata[15:0] > TBASE_MAX) ? TBASE_MAX : pwdata[15:0];
            if (paddr == ADDR_CTRL) begin
                run_r <= pwdata[CTRL_RUN_BIT];
                start_r <= pwdata[CTRL_START_BIT];
                jog_r <= pwdata[CTRL_JOG_BIT];
                rst_in_r <= pwdata[CTRL_RST_BIT];
                word_mode_r <= pwdata[CTRL_WORD_BIT];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            run_d_r <= 1'b0;
            jog_d_r <= 1'b0;
        end else begin
            run_d_r <= run_r;
            jog_d_r <= jog_r;
        end
    end

    // Step sequencing
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r <= MDS_IDLE;
            step_r <= '0;
            count_r <= '0;
            drum_completion_flag <= 1'b0;
        end else if (load_preset) begin
            state_r <= MDS_RUN; // R8
            step_r <= 4'(preset_r - 5'h01);
            count_r <= '0; // R19
            drum_completion_flag <= 1'b0; // R12
        end else if (!run_r) begin
            state_r <= MDS_IDLE;
        end else begin
            unique case (state_r)
                MDS_IDLE: begin
                    count_r <= count_r;
                end
                MDS_RUN: begin
                    if (advance) begin
                        count_r <= '0; // R19
                        if (step_r == 4'(NSTEP - 1)) begin
                            state_r <= MDS_DONE; // R7 R17
                            drum_completion_flag <= 1'b1; // R12
                        end else begin
                            step_r <= step_r + 4'h1;
                        end
                    end else if (timer_en && count_tick) begin
                        count_r <= count_r + 16'h0001;
                    end
                end
                MDS_DONE: begin
                    count_r <= '0;
                end
                default: begin
                    state_r <= MDS_IDLE;
                end
            endcase
        end
    end

    // Outputs follow the live mask, only in run mode
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            masked_drum_discrete_out <= '0;
            masked_drum_word_out <= '0;
        end else begin
            masked_drum_discrete_out <= (run_r && !word_mode_r) ? masked : 16'h0000; // R18 R13
            masked_drum_word_out <= (run_r && word_mode_r) ? masked : 16'h0000; // R14
        end
    end

    // APB read mux and slave answer
    always_comb begin
        rd_nxt = 32'h00000000;
        err_nxt = 1'b0;
        if (paddr == ADDR_COUNT)
            rd_nxt = {15'h0000, drum_completion_flag, count_r}; // R11 R12
        else if (paddr == ADDR_TIMER)
            rd_nxt = {16'h0000, timer_value};
        else if (paddr == ADDR_PRESET)
            rd_nxt = {27'h0000000, preset_r};
        else if (paddr == ADDR_CURSTEP)
            rd_nxt = {27'h0000000, 5'(step_r) + 5'h01};
        else if (paddr == ADDR_CTRL)
            rd_nxt = {27'h0000000, word_mode_r, rst_in_r, jog_r, start_r, run_r};
        else if (paddr == ADDR_TBASE)
            rd_nxt = {16'h0000, tbase_r};
        else if (paddr[11:8] == ADDR_MASK0[11:8] && paddr[7:6] == 2'b00 && paddr[1:0] == 2'b00)
            rd_nxt = {16'h0000, mask_r[sub[5:2]]};
        else if (paddr[11:8] == ADDR_PAT0[11:8] && paddr[7:6] == 2'b00 && paddr[1:0] == 2'b00)
            rd_nxt = {16'h0000, pat_r[sub[5:2]]};
        else if (paddr[11:8] == ADDR_CPS0[11:8] && paddr[7:6] == 2'b00 && paddr[1:0] == 2'b00)
            rd_nxt = {16'h0000, cps_r[sub[5:2]]};
        else if (paddr[11:8] == ADDR_EVS0[11:8] && paddr[7:6] == 2'b00 && paddr[1:0] == 2'b00)
            rd_nxt = {27'h0000000, evs_r[sub[5:2]]};
        else
            err_nxt = 1'b1;
        if (pwrite && (paddr == ADDR_COUNT || paddr == ADDR_TIMER || paddr == ADDR_CURSTEP))
            err_nxt = 1'b1; // R11
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= rd_en;
            pslverr <= rd_en && err_nxt;
            if (rd_en && !pwrite)
                prdata <= rd_nxt;
        end
    end

    // Sequencing checks
    step_clear_a: assert property (@(posedge ref_clk) disable iff (srst) // R19
        $changed(step_r) |-> count_r == 16'h0000) else $error("count not cleared");
    preset_load_a: assert property (@(posedge ref_clk) disable iff (srst) // R8
        rst_in_r |=> step_r == 4'($past(preset_r) - 5'h01)) else $error("preset not loaded");
    done_flag_a: assert property (@(posedge ref_clk) disable iff (srst) // R12
        (state_r == MDS_RUN && advance && step_r == 4'hF) |=> drum_completion_flag)
        else $error("completion flag missing");
    jog_step_a: assert property (@(posedge ref_clk) disable iff (srst) // R3
        (advance && jog_edge && step_r != 4'hF) |=> step_r == $past(step_r) + 4'h1)
        else $error("jog did not advance");
    timer_start_a: assert property (@(posedge ref_clk) disable iff (srst) // R4
        !start_r |-> !timer_en) else $error("timer without start");
    halt_done_a: assert property (@(posedge ref_clk) disable iff (srst) // R7
        (state_r == MDS_DONE && !load_preset) |=> $stable(step_r)) else $error("moved after done");
    done_hold_a: assert property (@(posedge ref_clk) disable iff (srst) // R7
        (state_r == MDS_DONE && run_r && !load_preset) |=> state_r == MDS_DONE)
        else $error("left done state");
    step_hold_a: assert property (@(posedge ref_clk) disable iff (srst) // R6
        (state_r == MDS_RUN && run_r && !load_preset && !advance) |=> $stable(step_r))
        else $error("step moved without cause");
    flag_clear_a: assert property (@(posedge ref_clk) disable iff (srst) // R12
        load_preset |=> !drum_completion_flag) else $error("completion flag not cleared");
    reset_hold_a: assert property (@(posedge ref_clk) disable iff (srst) // R8
        rst_in_r |=> state_r == MDS_RUN && count_r == 16'h0000) else $error("reset input ignored");
    event_gate_a: assert property (@(posedge ref_clk) disable iff (srst) // R5
        !ev_ok |-> !timer_en) else $error("timer ran without event");
    preset_range_a: assert property (@(posedge ref_clk) disable iff (srst) // R9
        preset_r >= PRESET_MIN && preset_r <= PRESET_MAX) else $error("preset out of range");

    // Output and register bus checks
    out_mask_a: assert property (@(posedge ref_clk) disable iff (srst) // R2
        (run_r && !word_mode_r) |=> masked_drum_discrete_out == $past(masked))
        else $error("output not masked");
    word_out_a: assert property (@(posedge ref_clk) disable iff (srst) // R14
        (run_r && word_mode_r) |=> masked_drum_word_out == $past(masked))
        else $error("word output not masked");
    discrete_off_a: assert property (@(posedge ref_clk) disable iff (srst) // R14
        word_mode_r |=> masked_drum_discrete_out == 16'h0000)
        else $error("discrete output in word mode");
    out_idle_a: assert property (@(posedge ref_clk) disable iff (srst) // R18
        !run_r |=> masked_drum_discrete_out == 16'h0000 && masked_drum_word_out == 16'h0000)
        else $error("output outside run mode");
    preset_write_a: assert property (@(posedge ref_clk) disable iff (srst) // R9
        (wr_en && paddr == ADDR_PRESET && pwdata[15:0] >= 16'(PRESET_MIN)
        && pwdata[15:0] <= 16'(PRESET_MAX)) |=> preset_r == $past(pwdata[4:0]))
        else $error("preset write lost");
    ro_error_a: assert property (@(posedge ref_clk) disable iff (srst) // R11
        (rd_en && pwrite && (paddr == ADDR_COUNT || paddr == ADDR_TIMER
        || paddr == ADDR_CURSTEP)) |=> pready && pslverr)
        else $error("status write not refused");
    ready_pulse_a: assert property (@(posedge ref_clk) disable iff (srst) // R11
        pready |=> !pready)
        else $error("ready held too long");
    slverr_ready_a: assert property (@(posedge ref_clk) disable iff (srst) // R11
        pslverr |-> pready)
        else $error("error without ready");
endmodule // mds_seq

// >>> dv/mds_ctl_model.sv
// Control program model: APB master and event contact driver
`timescale 1ns/1ps
module mds_ctl_model (
    input wire logic ref_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic [15:0] event_in
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        event_in = 16'h0000;
    end
    // Holds the request until pready is sampled high or 16 edges pass, then releases it
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output bit to);
        to = 1'b1;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (int i = 0; i < 16 && to; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) begin
                rd = prdata;
                err = pslverr;
                to = 1'b0;
            end
        end
        // Released lines flip so a stale value is never mistaken for a live one
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    task automatic set_events(input logic [15:0] v);
        event_in <= v;
    endtask
endmodule // mds_ctl_model

// >>> dv/tb_top.sv
// Self-checking bench for the masked drum sequencer
`timescale 1ns/1ps
module tb_top;
    import mds_pkg::*;
    localparam logic [31:0] C_RUN = 32'h1 << CTRL_RUN_BIT;
    localparam logic [31:0] C_GO = 32'h1 << CTRL_START_BIT;
    localparam logic [31:0] C_JOG = 32'h1 << CTRL_JOG_BIT;
    localparam logic [31:0] C_RST = 32'h1 << CTRL_RST_BIT;
    localparam logic [31:0] C_WRD = 32'h1 << CTRL_WORD_BIT;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, flag, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [15:0] event_in, dout, wout;
    logic [15:0] pat [16];
    logic [15:0] msk [16];
    logic [31:0] seed = 32'h0000FB79;
    bit to;
    int n_fail = 0;
    int check_count = 0;
    int p, q;
    always #20 ref_clk = ~ref_clk;
    mds_seq mds_seq_inst (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_in(event_in), .masked_drum_discrete_out(dout),
        .masked_drum_word_out(wout), .drum_completion_flag(flag));
    mds_ctl_model mds_ctl_inst (.ref_clk(ref_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_in(event_in));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected output word of a step numbered from 1
    function automatic logic [15:0] exp_out(input int s);
        return pat[s - 1] & msk[s - 1];
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d fails=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
        mds_ctl_inst.xfer(w, a, d, rdv, err, to);
        if (to) begin
            n_fail++;
            finish_test();
        end
        chk({31'h0, err}, {31'h0, e});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        acc(1'b1, a, d, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0, 1'b0);
        chk(rdv, exp);
    endtask
    // Outputs are registered: let one edge pass, then look mid-cycle
    task automatic outs(input logic [15:0] ed, input logic [15:0] ew);
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk({16'h0, dout}, {16'h0, ed});
        chk({16'h0, wout}, {16'h0, ew});
    endtask
    task automatic jog(input logic [31:0] c);
        wr(ADDR_CTRL, c | C_JOG);
        wr(ADDR_CTRL, c);
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        rd(ADDR_PRESET, 32'h1);
        rd(ADDR_TBASE, 32'hA);
        rd(ADDR_COUNT, 32'h0);
        outs(16'h0, 16'h0);
        acc(1'b1, ADDR_COUNT, 32'h5, 1'b1);
        acc(1'b1, ADDR_TIMER, 32'h5, 1'b1);
        acc(1'b1, ADDR_CURSTEP, 32'h5, 1'b1);
        acc(1'b0, 12'hFFC, 32'h0, 1'b1);
        rd(ADDR_COUNT, 32'h0);
        wr(ADDR_PRESET, 32'h0);
        rd(ADDR_PRESET, 32'h1);
        wr(ADDR_PRESET, 32'h1F);
        rd(ADDR_PRESET, 32'h10);
        wr(ADDR_TBASE, 32'h270F);
        rd(ADDR_TBASE, 32'h270F);
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            pat[i] = 16'(xs());
            msk[i] = (i == 0) ? 16'h0 : 16'(xs());
            wr(ADDR_MASK0 + 12'(4 * i), {16'h0, msk[i]});
            wr(ADDR_PAT0 + 12'(4 * i), {16'h0, pat[i]});
            p = int'(xs() % 32);
            wr(ADDR_EVS0 + 12'(4 * i), p);
            rd(ADDR_EVS0 + 12'(4 * i), p);
        end
        wr(ADDR_CPS0, 32'hFFFF);
        rd(ADDR_CPS0, 32'h270F);
        mds_ctl_inst.set_events(16'(xs()));
        p = 1 + int'(xs() % 15);
        wr(ADDR_PRESET, p);
        wr(ADDR_CTRL, C_RUN);
        rd(ADDR_CURSTEP, p);
        outs(exp_out(p), 16'h0);
        for (int s = p; s < 16; s++) begin
            jog(C_RUN);
            rd(ADDR_CURSTEP, s + 1);
            rd(ADDR_COUNT, 32'h0);
            msk[s] = 16'(xs());
            wr(ADDR_MASK0 + 12'(4 * s), {16'h0, msk[s]});
            outs(exp_out(s + 1), 16'h0);
        end
        $display("test jog done");
        wr(ADDR_CTRL, C_RUN | C_WRD);
        outs(16'h0, exp_out(16));
        jog(C_RUN | C_WRD);
        rd(ADDR_COUNT, 32'h10000);
        chk({31'h0, flag}, 32'h1);
        jog(C_RUN | C_WRD);
        rd(ADDR_COUNT, 32'h10000);
        outs(16'h0, exp_out(16));
        q = 1 + int'(xs() % 15);
        wr(ADDR_PRESET, q);
        wr(ADDR_CTRL, C_RUN | C_WRD | C_RST);
        rd(ADDR_CURSTEP, q);
        rd(ADDR_COUNT, 32'h0);
        jog(C_RUN | C_WRD | C_RST);
        rd(ADDR_CURSTEP, q);
        wr(ADDR_CTRL, C_RUN | C_WRD);
        jog(C_RUN | C_WRD);
        rd(ADDR_CURSTEP, q + 1);
        $display("test complete and reset done");
        wr(ADDR_CTRL, 32'h0);
        outs(16'h0, 16'h0);
        mds_ctl_inst.set_events(16'(xs()));
        wr(ADDR_CTRL, C_RUN | C_GO);
        rd(ADDR_CURSTEP, q);
        rd(ADDR_COUNT, 32'h0);
        rd(ADDR_TIMER, 32'h0);
        outs(exp_out(q), 16'h0);
        @(posedge ref_clk);
        srst <= 1'b1;
        @(posedge ref_clk);
        srst <= 1'b0;
        rd(ADDR_PRESET, 32'h1);
        outs(16'h0, 16'h0);
        $display("test run entry done");
        finish_test();
    end
endmodule // tb_top
